/* File: tsau_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tsau_consts.svh"
module tsau_top (
    input  wire logic                     clock,
    input  wire logic                     srst,
    input  wire logic [5:0]               tx_nibble_bus,
    input  wire logic                     tx_symbol_sync,
    input  wire logic                     tx_power_down_n,
    input  wire logic [25:0]              carrier_ftw,
    output logic                          master_clock_en,
    output logic [11:0]                   dac_sample,
    output logic                          dac_valid
);
    // system_clock_internal is clock; master clock is a divide-by-4 enable
    typedef struct packed {
        logic [1:0]          div;
        logic [2:0]          pd_sync;
        logic                pd_state;
        logic [6:0]          hold_cnt;
        tsau_pkg::tsau_nib_t nib;
        logic [5:0]          ihi;
        logic [5:0]          qhi;
        logic [5:0]          ilo;
        tsau_pkg::tsau_iq_t  sym;
        tsau_pkg::tsau_iq_t  f0;
        tsau_pkg::tsau_iq_t  f1;
        tsau_pkg::tsau_iq_t  f2;
        logic [1:0]          fir_ph;
        logic [1:0]          cic_ph;
        logic [39:0]         comb_d;
        logic [39:0]         integ;
        tsau_pkg::tsau_iq_t  base;
        logic [25:0]         phase;
        logic [11:0]         dac;
        logic                dv;
    } tsau_state_t;

    tsau_state_t s_q;
    tsau_state_t s_d;

    // triangle approximation of sine, quadrant-folded on the top phase bits
    function automatic logic signed [11:0] tsau_sin(input logic [25:0] ph);
        logic [7:0]         a;
        logic signed [11:0] mag;
        logic signed [11:0] v;
        a   = ph[25:18];
        mag = 12'sh000;
        v   = 12'sh000;
        if (a[6]) begin
            mag = signed'({1'b0, ~a[5:0], 5'h00});
        end else begin
            mag = signed'({1'b0, a[5:0], 5'h00});
        end
        if (a[7]) begin
            v = -mag;
        end else begin
            v = mag;
        end
        return v;
    endfunction

    // [1 2 1]/4 taps over the last three symbols, unity gain at dc
    function automatic logic signed [12:0] tsau_fir(input logic signed [11:0] x0,
                                                     input logic signed [11:0] x1,
                                                     input logic signed [11:0] x2);
        logic signed [13:0] acc;
        acc = 14'(x0) + 14'(x1) + 14'(x1) + 14'(x2);
        return 13'(acc >>> 2);
    endfunction

    // one integrator step; the comb difference enters only on master strobes
    function automatic logic signed [19:0] tsau_integ(input logic signed [19:0] acc,
                                                      input logic signed [12:0] x,
                                                      input logic signed [19:0] prev,
                                                      input logic               strobe);
        logic signed [19:0] step;
        step = 20'sh00000;
        if (strobe) begin
            step = 20'(x) - prev;
        end
        return acc + step;
    endfunction

    // i times cosine plus q times sine, scaled back to 12 bits
    function automatic logic [11:0] tsau_mod(input logic signed [11:0] i,
                                             input logic signed [11:0] q,
                                             input logic [25:0]        ph);
        logic signed [23:0] pi;
        logic signed [23:0] pq;
        logic signed [23:0] sum;
        pi  = 24'(i * tsau_sin(ph + 26'h1000000));
        pq  = 24'(q * tsau_sin(ph));
        sum = pi + pq;
        return sum[22:11];
    endfunction

    // first nibble of a component is its upper half
    function automatic logic signed [11:0] tsau_join(input logic [5:0] hi,
                                                     input logic [5:0] lo);
        return signed'({hi, lo});
    endfunction

    // a pin level counts once the two oldest stages agree
    function automatic logic tsau_settled(input logic [2:0] sync,
                                          input logic       prev);
        logic v;
        v = prev;
        if (sync[2] == sync[1]) begin
            v = sync[2];
        end
        return v;
    endfunction

    logic               mclk_en;
    logic               pd_n;
    logic               cic_rst;
    logic signed [12:0] fir_i;
    logic signed [12:0] fir_q;
    logic signed [19:0] ci;
    logic signed [19:0] cq;
    logic signed [19:0] ii;
    logic signed [19:0] iq;

    always_comb begin
        s_d      = s_q;
        mclk_en  = (s_q.div == 2'h3);
        pd_n     = s_q.pd_state;
        cic_rst  = !pd_n || (s_q.hold_cnt != 7'h00);
        fir_i    = 13'sh0;
        fir_q    = 13'sh0;
        ci       = 20'sh0;
        cq       = 20'sh0;
        ii       = 20'sh0;
        iq       = 20'sh0;
        s_d.pd_sync = {s_q.pd_sync[1:0], tx_power_down_n};
        s_d.pd_state = tsau_settled(s_q.pd_sync, s_q.pd_state);
        if (pd_n) begin
            s_d.div = s_q.div + 2'h1;
        end else begin
            s_d.div = 2'h0;
        end
        if (!s_q.pd_state && s_d.pd_state) begin
            s_d.hold_cnt = 7'(`TSAU_CIC_HOLD);
        end else if (mclk_en && s_q.hold_cnt != 7'h00) begin
            s_d.hold_cnt = s_q.hold_cnt - 7'h01;
        end
        if (mclk_en) begin
            // one nibble per master cycle, sync restarts symbol
            if (tx_symbol_sync || s_q.nib == tsau_pkg::TSAU_N_QLO) begin
                s_d.ihi = tx_nibble_bus;
                s_d.nib = tsau_pkg::TSAU_N_IHI;
            end else begin
                case (s_q.nib)
                    tsau_pkg::TSAU_N_IHI: begin
                        s_d.ilo = tx_nibble_bus;
                        s_d.nib = tsau_pkg::TSAU_N_ILO;
                    end
                    tsau_pkg::TSAU_N_ILO: begin
                        s_d.qhi = tx_nibble_bus;
                        s_d.nib = tsau_pkg::TSAU_N_QHI;
                    end
                    tsau_pkg::TSAU_N_QHI: begin
                        // assemble I from nibbles 1,2 and Q from 3,4
                        s_d.sym.i = tsau_join(s_q.ihi, s_q.ilo);
                        s_d.sym.q = tsau_join(s_q.qhi, tx_nibble_bus);
                        s_d.nib   = tsau_pkg::TSAU_N_QLO;
                    end
                    default: s_d.nib = tsau_pkg::TSAU_N_IHI;
                endcase
            end
            // 4x FIR interpolator, [1 2 1]/4 low-pass with the same taps on every phase, each output held four master cycles
            s_d.fir_ph = s_q.fir_ph + 2'h1;
            if (s_q.fir_ph == 2'h0) begin
                s_d.f0 = s_q.sym;
                s_d.f1 = s_q.f0;
                s_d.f2 = s_q.f1;
            end
            fir_i = tsau_fir(s_q.f0.i, s_q.f1.i, s_q.f2.i);
            fir_q = tsau_fir(s_q.f0.q, s_q.f1.q, s_q.f2.q);
            // comb delay holds the previous filter output
            s_d.comb_d = {20'(fir_i), 20'(fir_q)};
        end
        // 4x CIC: comb at master rate, zero-stuffed integrator at system rate
        ci = signed'(s_q.comb_d[39:20]);
        cq = signed'(s_q.comb_d[19:0]);
        ii = tsau_integ(signed'(s_q.integ[39:20]), fir_i, ci, mclk_en);
        iq = tsau_integ(signed'(s_q.integ[19:0]), fir_q, cq, mclk_en);
        s_d.integ  = {ii, iq};
        s_d.base.i = ii[11:0];
        s_d.base.q = iq[11:0];
        if (cic_rst) begin
            s_d.integ  = 40'h0;
            s_d.comb_d = 40'h0;
            s_d.base   = '0;
        end
        // DDS phase accumulator, 26-bit tuning word on system clock
        s_d.phase = s_q.phase + carrier_ftw;
        // i on the cosine, q on the sine, carriers 90 degrees apart
        s_d.dac = tsau_mod(s_q.base.i, s_q.base.q, s_q.phase);
        s_d.dv  = pd_n;
        if (!pd_n) begin
            s_d.phase = 26'h0;
            s_d.dac   = 12'h000;
            s_d.fir_ph = 2'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign master_clock_en = mclk_en;
    assign dac_sample      = s_q.dac;
    assign dac_valid       = s_q.dv;
endmodule
`default_nettype wire

/* File: tsau_consts.svh */
`ifndef TSAU_CONSTS_SVH
`define TSAU_CONSTS_SVH
`define TSAU_NIB_W        6
`define TSAU_COMP_W       12
`define TSAU_FTW_W        26
`define TSAU_PHASE_W      26
`define TSAU_LUT_A_W      6
`define TSAU_MCLK_DIV     4
`define TSAU_FIR_L        4
`define TSAU_CIC_L        4
`define TSAU_CIC_HOLD     80
`define TSAU_CIC_W        20
`endif

/* File: tsau_pkg.sv */
package tsau_pkg;
    typedef logic signed [11:0] tsau_samp_t;
    typedef struct packed {
        tsau_samp_t i;
        tsau_samp_t q;
    } tsau_iq_t;
    typedef enum logic [1:0] {
        TSAU_N_IHI,
        TSAU_N_ILO,
        TSAU_N_QHI,
        TSAU_N_QLO
    } tsau_nib_t;
endpackage

/* File: tsau_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module tsau_sva (
    input wire logic        clock,
    input wire logic        srst,
    input wire logic        tx_power_down_n,
    input wire logic        master_clock_en,
    input wire logic [11:0] dac_sample,
    input wire logic        dac_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    a_en_spacing: assert property (master_clock_en |=> !master_clock_en[*3])
        else $error("master clock pulses too close");
    a_pd_stop: assert property ((!tx_power_down_n)[*6] |-> !master_clock_en)
        else $error("master clock runs in power down");
    a_pd_idle: assert property ((!tx_power_down_n)[*8] |-> !dac_valid)
        else $error("path valid in power down");
    a_run_start: assert property ($rose(tx_power_down_n) |-> ##[1:12] master_clock_en)
        else $error("clocks not restarted");
    a_cic_hold: assert property ($rose(tx_power_down_n) |-> ##6 (dac_sample == 12'h000)[*8])
        else $error("output not held at zero");
    a_hold_mid: assert property ($rose(tx_power_down_n) |-> ##150 dac_sample == 12'h000)
        else $error("filter reset released early");
    a_hold_end: assert property ($rose(tx_power_down_n) |-> ##300 dac_sample == 12'h000)
        else $error("filter reset shorter than hold");
    a_valid_run: assert property (master_clock_en ##4 master_clock_en |-> dac_valid)
        else $error("valid low while running");
    c_en: cover property (master_clock_en);
    c_wake: cover property ($rose(tx_power_down_n));
    c_out: cover property (dac_sample != 12'h000);
endmodule
bind tsau_top tsau_sva u_sva (.clock(clock), .srst(srst), .tx_power_down_n(tx_power_down_n),
    .master_clock_en(master_clock_en), .dac_sample(dac_sample), .dac_valid(dac_valid));
`default_nettype wire

/* File: tsau_host.sv */
`timescale 1ns/10ps
`default_nettype none
module tsau_host (
    input  wire logic               clock,
    input  wire logic               master_clock_en,
    input  wire tsau_pkg::tsau_iq_t sym,
    output logic [5:0]              tx_nibble_bus,
    output logic                    tx_symbol_sync
);
    logic [1:0] k_q;
    logic [5:0] nib;
    initial {k_q, tx_nibble_bus, tx_symbol_sync} = 9'h000;
    always_comb begin
        case (k_q)
            2'h0: nib = sym.i[11:6];
            2'h1: nib = sym.i[5:0];
            2'h2: nib = sym.q[11:6];
            default: nib = sym.q[5:0];
        endcase
    end
    always @(negedge clock) begin
        if (master_clock_en) begin
            tx_nibble_bus <= nib;
            tx_symbol_sync <= (k_q == 2'h0);
            k_q <= k_q + 2'h1;
        end else begin
            // not taken: bus inverts each clock, showing the stale nibble and its inverse in turn
            tx_nibble_bus <= ~tx_nibble_bus;
            tx_symbol_sync <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                 clock = 1'b0;
    logic                 srst = 1'b1;
    logic                 pd_n = 1'b0;
    tsau_pkg::tsau_iq_t   sym = 24'h000000;
    logic [5:0]           nib;
    logic [25:0]          ftw = 26'h0000000;
    logic                 sync, en, valid;
    tsau_pkg::tsau_samp_t dac;
    int                   num_errors = 0;
    int                   n_compared = 0;
    tsau_host u_host (.clock(clock), .master_clock_en(en), .sym(sym),
        .tx_nibble_bus(nib), .tx_symbol_sync(sync));
    tsau_top DUT (.clock(clock), .srst(srst), .tx_nibble_bus(nib), .tx_symbol_sync(sync),
        .tx_power_down_n(pd_n), .carrier_ftw(ftw), .master_clock_en(en),
        .dac_sample(dac), .dac_valid(valid));
    initial forever #5 clock = ~clock;
    task chk(input string nm, input tsau_pkg::tsau_samp_t lo, input tsau_pkg::tsau_samp_t hi,
        input tsau_pkg::tsau_samp_t got);
        n_compared++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    task end_of_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task lvl(input string nm, input tsau_pkg::tsau_iq_t s, input tsau_pkg::tsau_samp_t lo,
        input tsau_pkg::tsau_samp_t hi);
        sym = s;
        repeat (400) @(negedge clock);
        chk(nm, lo, hi, dac);
    endtask
    task t_pd;
        repeat (20) begin
            @(negedge clock);
            chk("en", 12'h000, 12'h000, {11'h000, en});
            chk("valid", 12'h000, 12'h000, {11'h000, valid});
        end
    endtask
    task t_hold;
        pd_n = 1'b1;
        sym = 24'h7ff000;
        repeat (300) @(negedge clock);
        chk("hold", 12'h000, 12'h000, dac);
    endtask
    task t_sign;
        // zero carrier phase: output follows sign of i
        lvl("i pos", 24'h7ff000, 12'h040, 12'h7ff);
        lvl("i neg", 24'h801000, 12'h800, 12'hfc0);
    endtask
    task t_quad;
        lvl("q only", 24'h0007ff, 12'hfc0, 12'h040);
    endtask
    task t_carrier;
        tsau_pkg::tsau_samp_t mx;
        tsau_pkg::tsau_samp_t mn;
        // quarter turn per clock: cosine term swings full scale both ways
        mx  = 12'h800;
        mn  = 12'h7ff;
        ftw = 26'h1000000;
        sym = 24'h7ff000;
        repeat (400) @(negedge clock);
        repeat (8) begin
            @(negedge clock);
            if (dac > mx) mx = dac;
            if (dac < mn) mn = dac;
        end
        chk("carrier peak", 12'h700, 12'h7ff, mx);
        chk("carrier trough", 12'h800, 12'h900, mn);
        ftw = 26'h0000000;
    endtask
    initial begin
        repeat (5) @(negedge clock);
        srst = 1'b0;
        t_pd();
        t_hold();
        t_sign();
        t_quad();
        t_carrier();
        end_of_test();
    end
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
